// ===== rtl/mii_rx_pins.sv
/*
 * mii receive pin driver and power-up strap capture, with apb registers.
 * assumes the decoder feeds nibbles on rx_clk, the recovered receive
 * clock; board straps are read while the rxd pins are released in reset.
 */
// The implementer's own choices: the APB register port and the register offsets.
// Functional notes
// - four rxd lines, bit 0 least significant
// - rxd0..2 strap sampled as mode default
// - rxd3 strap picks shared irq pin function
// - strap high or floating: active-low interrupt
// - strap low: transmit error or symbol bit
// - rmii: rxd2 and rxd3 carry no data
// - receive error flags errors in frame
// - symbol mode: error pin carries symbol msb
// - data valid only while decoded nibbles shown
// - rmii: valid moves onto combined carrier pin
// - receive clock 25 or 2.5 mhz, mii only
// - rmii select latched at reset release
`default_nettype none

module mii_rx_pins (
	input  wire logic        clk,
	input  wire logic        srst,
	// apb slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	// decoder side, on the receive clock
	input  wire logic        rx_clk,
	input  wire logic [3:0]  dec_nibble,
	input  wire logic        dec_sym_msb,
	input  wire logic        dec_valid,
	input  wire logic        dec_err,
	input  wire logic        dec_carrier,
	// rxd pins, shared with the mode and irq straps
	input  wire logic [3:0]  rxd_pin_i,
	output var  logic [3:0]  rxd_pin_o,
	output var  logic [3:0]  rxd_pin_oe_n,
	output var  logic        rx_err_pin,
	output var  logic        rx_dv_pin,
	output var  logic        carrier_and_valid_combined,
	input  wire logic        col_strap_i,
	// shared interrupt / transmit error / symbol bit pin
	input  wire logic        irq_req,
	input  wire logic        irq_pin_i,
	output var  logic        irq_out_low,
	output var  logic        irq_oe_n,
	output var  logic        tx_error_function,
	output var  logic        tx_symbol_msb,
	// latched straps
	output var  logic        opmode_strap_bit0,
	output var  logic        opmode_strap_bit1,
	output var  logic        opmode_strap_bit2,
	output var  logic        irq_pin_function_strap,
	output var  logic        rmii_sel
);

	// pins synchronised into clk: rxd[3:0], irq pin, col strap
	logic [5:0] pin_sync;
	// receive-side state brought into clk: error toggle, valid level
	logic [1:0] rx2c_sync;
	// control brought into rx_clk: reset, drive, symbol, rmii
	logic [3:0] c2rx_sync;

	bit_sync #(.WIDTH(6)) u_pin_sync (
		.clk (clk),
		.d   ({col_strap_i, irq_pin_i, rxd_pin_i}),
		.q   (pin_sync)
	);

	// strap fsm and latched straps
	mii_rx_pkg::strap_state_e state_r, state_nxt;
	logic [2:0] mode_r,     mode_nxt;     // operating mode default
	logic       irqsel_r,   irqsel_nxt;   // 1: pin is interrupt out
	logic       rmii_r,     rmii_nxt;     // 1: reduced pin interface
	logic       drive_r,    drive_nxt;    // rxd pins may be driven

	// sample straps once, two cycles after reset is released
	always_comb begin
		state_nxt  = state_r;
		mode_nxt   = mode_r;
		irqsel_nxt = irqsel_r;
		rmii_nxt   = rmii_r;
		drive_nxt  = drive_r;
		case (state_r)
			mii_rx_pkg::ST_HOLD: begin
				state_nxt = mii_rx_pkg::ST_CAPTURE;
			end
			mii_rx_pkg::ST_CAPTURE: begin
				mode_nxt   = pin_sync[2:0];
				irqsel_nxt = pin_sync[3];
				rmii_nxt   = pin_sync[5];
				drive_nxt  = 1'b1;
				state_nxt  = mii_rx_pkg::ST_RUN;
			end
			mii_rx_pkg::ST_RUN: begin
				state_nxt = mii_rx_pkg::ST_RUN;
			end
			default: begin
				state_nxt = mii_rx_pkg::ST_HOLD;
			end
		endcase
	end

	// pins stay released throughout reset so the board straps win
	always_ff @(posedge clk) begin
		if (srst) begin
			state_r  <= mii_rx_pkg::ST_HOLD;
			mode_r   <= mii_rx_pkg::MODE_RESET;
			irqsel_r <= 1'b1;
			rmii_r   <= 1'b0;
			drive_r  <= 1'b0;
		end else begin
			state_r  <= state_nxt;
			mode_r   <= mode_nxt;
			irqsel_r <= irqsel_nxt;
			rmii_r   <= rmii_nxt;
			drive_r  <= drive_nxt;
		end
	end

	// apb registers
	logic [1:0]  ctrl_r,   ctrl_nxt;    // symbol mode, speed 100
	logic [15:0] errcnt_r, errcnt_nxt;  // frames seen with errors
	logic        errtg_r,  errtg_nxt;   // last seen error toggle
	logic [31:0] prdata_r, prdata_nxt;
	logic        pready_r, pready_nxt;
	logic        pslverr_r, pslverr_nxt;
	logic        access;
	logic        err_evt;

	// one wait state: answer lands on the second access cycle
	assign access  = psel & penable & ~pready_r;
	assign err_evt = rx2c_sync[0] ^ errtg_r;

	// decode, read mux and counter update
	always_comb begin
		ctrl_nxt    = ctrl_r;
		errcnt_nxt  = errcnt_r;
		errtg_nxt   = rx2c_sync[0];
		prdata_nxt  = mii_rx_pkg::RDATA_ZERO;
		pready_nxt  = access;
		pslverr_nxt = 1'b0;
		// saturating count of erroneous frames
		if (err_evt && errcnt_r != mii_rx_pkg::ERRCNT_MAX) begin
			errcnt_nxt = errcnt_r + mii_rx_pkg::ERRCNT_ONE;
		end
		if (access) begin
			if (paddr == mii_rx_pkg::REG_CTRL) begin
				if (pwrite) begin
					ctrl_nxt = pwdata[mii_rx_pkg::CTRL_W-1:0];
				end
				prdata_nxt[mii_rx_pkg::CTRL_W-1:0] = ctrl_r;
			end else if (paddr == mii_rx_pkg::REG_STATUS) begin
				prdata_nxt[mii_rx_pkg::STAT_MODE_MSB:
				           mii_rx_pkg::STAT_MODE_LSB] = mode_r;
				prdata_nxt[mii_rx_pkg::STAT_IRQ_BIT]  = irqsel_r;
				prdata_nxt[mii_rx_pkg::STAT_RMII_BIT] = rmii_r;
				prdata_nxt[mii_rx_pkg::STAT_DV_BIT]   = rx2c_sync[1];
				prdata_nxt[mii_rx_pkg::STAT_SPD_BIT]  =
					ctrl_r[mii_rx_pkg::CTRL_SPD_BIT];
				prdata_nxt[mii_rx_pkg::STAT_SYM_BIT]  =
					ctrl_r[mii_rx_pkg::CTRL_SYM_BIT];
			end else if (paddr == mii_rx_pkg::REG_ERRCNT) begin
				// any write clears; an event in the same cycle survives
				if (pwrite) begin
					errcnt_nxt = err_evt ? mii_rx_pkg::ERRCNT_ONE
					                     : '0;
				end
				prdata_nxt[mii_rx_pkg::ERRCNT_W-1:0] = errcnt_r;
			end else begin
				// unmapped: error response, reads zero
				pslverr_nxt = 1'b1;
			end
		end
	end

	// register stage for the bus slave
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_r    <= mii_rx_pkg::CTRL_RESET;
			errcnt_r  <= '0;
			errtg_r   <= 1'b0;
			prdata_r  <= mii_rx_pkg::RDATA_ZERO;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			ctrl_r    <= ctrl_nxt;
			errcnt_r  <= errcnt_nxt;
			errtg_r   <= errtg_nxt;
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// shared irq pin and latched strap outputs
	logic irq_o_r, irq_o_nxt;
	logic irq_oe_r, irq_oe_nxt;
	logic tx_error_function_r, tx_error_function_nxt;
	logic txsym_r, txsym_nxt;

	// open-drain: only pull low while an interrupt is pending
	always_comb begin
		irq_o_nxt  = 1'b1;
		irq_oe_nxt = 1'b1;
		tx_error_function_nxt   = 1'b0;
		txsym_nxt  = 1'b0;
		if (irqsel_r) begin
			irq_o_nxt  = ~irq_req;
			irq_oe_nxt = ~irq_req;
		end else if (ctrl_r[mii_rx_pkg::CTRL_SYM_BIT]) begin
			txsym_nxt = pin_sync[4];
		end else begin
			tx_error_function_nxt = pin_sync[4];
		end
		if (state_r != mii_rx_pkg::ST_RUN) begin
			irq_o_nxt  = 1'b1;
			irq_oe_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			irq_o_r  <= 1'b1;
			irq_oe_r <= 1'b1;
			tx_error_function_r   <= 1'b0;
			txsym_r  <= 1'b0;
		end else begin
			irq_o_r  <= irq_o_nxt;
			irq_oe_r <= irq_oe_nxt;
			tx_error_function_r   <= tx_error_function_nxt;
			txsym_r  <= txsym_nxt;
		end
	end

	// receive clock domain
	bit_sync #(.WIDTH(4)) u_c2rx_sync (
		.clk (rx_clk),
		.d   ({rmii_r, ctrl_r[mii_rx_pkg::CTRL_SYM_BIT], drive_r, srst}),
		.q   (c2rx_sync)
	);

	logic [3:0] rxd_r, rxd_nxt;
	logic [3:0] oe_n_r, oe_n_nxt;
	logic       er_r, er_nxt;
	logic       dv_r, dv_nxt;
	logic       cdv_r, cdv_nxt;
	logic       fr_err_r, fr_err_nxt;   // error seen in current frame
	logic       tgl_r, tgl_nxt;         // one toggle per bad frame

	// rmii and drive are static after reset and symbol mode is one level, so per-bit sync is safe
	always_comb begin
		rxd_nxt    = '0;
		oe_n_nxt   = '1;
		er_nxt     = 1'b0;
		dv_nxt     = 1'b0;
		cdv_nxt    = 1'b0;
		fr_err_nxt = fr_err_r;
		tgl_nxt    = tgl_r;
		if (c2rx_sync[1]) begin
			oe_n_nxt = '0;
			rxd_nxt = dec_valid ? dec_nibble : '0;
			dv_nxt = dec_valid;
			er_nxt = c2rx_sync[2] ? dec_sym_msb : dec_err;
			if (c2rx_sync[3]) begin
				rxd_nxt[3:2]  = '0;
				oe_n_nxt[3:2] = '1;
				dv_nxt  = 1'b0;
				cdv_nxt = dec_carrier | dec_valid;
			end
		end
		// count each frame with an error once, at its end
		if (dec_valid && dec_err) begin
			fr_err_nxt = 1'b1;
		end else if (!dec_valid) begin
			fr_err_nxt = 1'b0;
			if (fr_err_r) begin
				tgl_nxt = ~tgl_r;
			end
		end
	end

	always_ff @(posedge rx_clk) begin
		if (c2rx_sync[0]) begin
			rxd_r    <= '0;
			oe_n_r   <= '1;
			er_r     <= 1'b0;
			dv_r     <= 1'b0;
			cdv_r    <= 1'b0;
			fr_err_r <= 1'b0;
			tgl_r    <= 1'b0;
		end else begin
			rxd_r    <= rxd_nxt;
			oe_n_r   <= oe_n_nxt;
			er_r     <= er_nxt;
			dv_r     <= dv_nxt;
			cdv_r    <= cdv_nxt;
			fr_err_r <= fr_err_nxt;
			tgl_r    <= tgl_nxt;
		end
	end

	bit_sync #(.WIDTH(2)) u_rx2c_sync (
		.clk (clk),
		.d   ({dv_r, tgl_r}),
		.q   (rx2c_sync)
	);

	// output assignments, all straight from flops
	assign prdata                     = prdata_r;
	assign pready                     = pready_r;
	assign pslverr                    = pslverr_r;
	assign rxd_pin_o                  = rxd_r;
	assign rxd_pin_oe_n               = oe_n_r;
	assign rx_err_pin                 = er_r;
	assign rx_dv_pin                  = dv_r;
	assign carrier_and_valid_combined = cdv_r;
	assign irq_out_low                = irq_o_r;
	assign irq_oe_n                   = irq_oe_r;
	assign tx_error_function          = tx_error_function_r;
	assign tx_symbol_msb              = txsym_r;
	assign opmode_strap_bit0          = mode_r[0];
	assign opmode_strap_bit1          = mode_r[1];
	assign opmode_strap_bit2          = mode_r[2];
	assign irq_pin_function_strap     = irqsel_r;
	assign rmii_sel                   = rmii_r;

endmodule : mii_rx_pins

`default_nettype wire

// ===== rtl/mii_rx_pkg.sv
/*
 * constants for the mii receive pins and power-up straps block:
 * apb register map, field positions, reset values, strap fsm states.
 * assumes a 32-bit apb slave with byte addresses on an 8-bit paddr.
 */
`default_nettype none

package mii_rx_pkg;

	// apb address width and word offsets
	localparam int             ADDR_W       = 8;
	localparam logic [7:0]     REG_CTRL     = 8'h00;
	localparam logic [7:0]     REG_STATUS   = 8'h04;
	localparam logic [7:0]     REG_ERRCNT   = 8'h08;

	// control register fields
	localparam int             CTRL_SYM_BIT = 0;
	localparam int             CTRL_SPD_BIT = 1;
	localparam int             CTRL_W       = 2;
	localparam logic [1:0]     CTRL_RESET   = 2'h2;

	// status register fields
	localparam int             STAT_MODE_LSB = 0;
	localparam int             STAT_MODE_MSB = 2;
	localparam int             STAT_IRQ_BIT  = 3;
	localparam int             STAT_RMII_BIT = 4;
	localparam int             STAT_DV_BIT   = 5;
	localparam int             STAT_SPD_BIT  = 6;
	localparam int             STAT_SYM_BIT  = 7;

	// frame error counter
	localparam int             ERRCNT_W     = 16;
	localparam logic [15:0]    ERRCNT_ONE   = 16'h0001;
	localparam logic [15:0]    ERRCNT_MAX   = 16'hffff;

	// strap defaults: interrupt pin function, mii, mode all ones
	localparam logic [2:0]     MODE_RESET   = 3'h7;
	localparam logic [31:0]    RDATA_ZERO   = 32'h0000_0000;

	// strap sampling states, gray along hold -> capture -> run
	typedef enum logic [1:0] {
		ST_HOLD    = 2'h0,
		ST_CAPTURE = 2'h1,
		ST_RUN     = 2'h3
	} strap_state_e;

endpackage : mii_rx_pkg

`default_nettype wire

// ===== rtl/bit_sync.sv
/*
 * two flip-flop synchroniser for a bundle of independent levels.
 * assumes each bit is a level or a toggle, never a multi-bit word.
 */
`default_nettype none

module bit_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic [WIDTH-1:0] d,
	output var  logic [WIDTH-1:0] q
);

	// first stage, read only by the second stage
	logic [WIDTH-1:0] meta_r;

	// one pair of flops per bit
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			always_ff @(posedge clk) begin
				meta_r[gi] <= d[gi];
				q[gi]      <= meta_r[gi];
			end
		end
	endgenerate

endmodule : bit_sync

`default_nettype wire

// ===== verification/mii_rx_props.sv
/* assertions on the mii receive pin block ports
   assumes binding into every mii_rx_pins instance */
`default_nettype none
module mii_rx_props (
	input	wire logic		clk,
	input	wire logic		srst,
	input	wire logic		psel,
	input	wire logic		penable,
	input	wire logic		pready,
	input	wire logic		pslverr,
	input	wire logic [31:0]	prdata,
	input	wire logic		rx_clk,
	input	wire logic [3:0]	dec_nibble,
	input	wire logic		dec_valid,
	input	wire logic [3:0]	rxd_pin_o,
	input	wire logic [3:0]	rxd_pin_oe_n,
	input	wire logic		rx_dv_pin,
	input	wire logic		irq_req,
	input	wire logic		irq_out_low,
	input	wire logic		irq_oe_n,
	input	wire logic		opmode_strap_bit0,
	input	wire logic		opmode_strap_bit1,
	input	wire logic		opmode_strap_bit2,
	input	wire logic		irq_pin_function_strap,
	input	wire logic		rmii_sel
);
	logic [2:0]	run_r;		// clocks since reset release
	logic [2:0]	run_nxt;
	logic [4:0]	straps;		// latched strap bundle
	// saturating count, straps settle well before it tops out
	always_comb begin
		run_nxt = (run_r == 3'h7) ? run_r : run_r + 3'h1;
		straps = {rmii_sel, irq_pin_function_strap, opmode_strap_bit2,
			opmode_strap_bit1, opmode_strap_bit0};
	end
	always_ff @(posedge clk) begin
		if (srst) run_r <= 3'h0;
		else run_r <= run_nxt;
	end
	sequence apb_take;
		psel && penable && !pready;
	endsequence
	sequence nib_in;
		dec_valid && !rmii_sel;
	endsequence
	chk_apb_answer: assert property (@(posedge clk) disable iff (srst)
		apb_take |=> pready) else $error("access without pready");
	chk_slverr_zero: assert property (@(posedge clk) disable iff (srst)
		pready && pslverr |-> prdata == 32'h0000_0000)
		else $error("error read data not zero");
	chk_irq_drive: assert property (@(posedge clk) disable iff (srst)
		irq_pin_function_strap && irq_req |=> !irq_oe_n && !irq_out_low)
		else $error("interrupt not driven low");
	chk_irq_refuse: assert property (@(posedge clk) disable iff (srst)
		!irq_pin_function_strap |-> irq_oe_n)
		else $error("shared pin driven in tx error mode");
	chk_strap_hold: assert property (@(posedge clk) disable iff (srst)
		run_r == 3'h7 |-> $stable(straps))
		else $error("straps moved after capture");
	chk_rmii_upper: assert property (@(posedge rx_clk) disable iff (srst)
		rmii_sel |-> rxd_pin_oe_n[3:2] == 2'h3 && rxd_pin_o[3:2] == 2'h0)
		else $error("upper rxd used in rmii");
	chk_dv_follow: assert property (@(posedge rx_clk) disable iff (srst)
		nib_in |=> rx_dv_pin && rxd_pin_o == $past(dec_nibble))
		else $error("nibble not presented");
	chk_dv_drop: assert property (@(posedge rx_clk) disable iff (srst)
		!dec_valid |=> !rx_dv_pin) else $error("valid without data");
	chk_rmii_dv: assert property (@(posedge rx_clk) disable iff (srst)
		rmii_sel |-> !rx_dv_pin) else $error("valid pin used in rmii");
endmodule : mii_rx_props
bind mii_rx_pins mii_rx_props u_props (.clk, .srst, .psel, .penable,
	.pready, .pslverr, .prdata, .rx_clk, .dec_nibble, .dec_valid,
	.rxd_pin_o, .rxd_pin_oe_n, .rx_dv_pin, .irq_req, .irq_out_low,
	.irq_oe_n, .opmode_strap_bit0, .opmode_strap_bit1, .opmode_strap_bit2,
	.irq_pin_function_strap, .rmii_sel);
`default_nettype wire

// ===== verification/mac_rx_model.sv
/* mac side of the receive pins, plus board strap resistors
   assumes the bench sets strap levels and the tx error level */
`default_nettype none
module mac_rx_model (
	input	wire logic		rx_clk,
	input	wire logic [3:0]	strap,
	input	wire logic		strap_col,
	input	wire logic		txe,
	input	wire logic		rmii,
	input	wire logic [3:0]	rxd_pin_o,
	input	wire logic [3:0]	rxd_pin_oe_n,
	input	wire logic		rx_err_pin,
	input	wire logic		rx_dv_pin,
	input	wire logic		irq_out_low,
	input	wire logic		irq_oe_n,
	output	var logic [3:0]	rxd_pin_i,
	output	var logic		col_strap_i,
	output	var logic		irq_pin_i,
	output	var logic [5:0]	cap
);
	timeunit 1ns;
	timeprecision 100ps;
	// board straps on rxd
	// a released line falls back to its strap resistor
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			rxd_pin_i[i] = rxd_pin_oe_n[i] ? strap[i] : rxd_pin_o[i];
		end
		col_strap_i = strap_col;
		irq_pin_i = irq_oe_n ? txe : irq_out_low;
	end
	// sample on rx clock, error ignored in rmii
	always_ff @(posedge rx_clk) begin
		cap <= {rx_err_pin & ~rmii, rx_dv_pin, rxd_pin_i};
	end
endmodule : mac_rx_model
`default_nettype wire

// ===== verification/tb_top.sv
/* bench: apb master, decoder stimulus, queued result checks
   assumes the mac model resolves all shared pins */
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic	clk = 0, rx_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]	paddr = 8'h00;
	logic [31:0]	pwdata = 32'h0000_0000, prdata;
	logic	pready, pslverr, irq_req = 0, txe = 1, col = 0, rmii;
	logic [3:0]	dec_nibble = 4'h0, strap = 4'hf, rxd_i, rxd_o, rxd_oe_n;
	logic	dec_sym_msb = 0, dec_valid = 0, dec_err = 0, dec_carrier = 0;
	logic	err_p, dv_p, col_i, irq_i, irq_lo, irq_oe_n, txf;
	logic [5:0]	cap;
	logic [32:0]	q_apb[$];	// expected {pslverr, prdata}
	logic [4:0]	q_rx[$];	// expected {err, nibble}
	int	error_cnt = 0, tests_run = 0, cyc = 0;
	always #4 clk = ~clk;
	always #62.5 rx_clk = ~rx_clk;
	mii_rx_pins u_dut (.clk, .srst, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .rx_clk, .dec_nibble,
		.dec_sym_msb, .dec_valid, .dec_err, .dec_carrier, .rxd_pin_i(rxd_i),
		.rxd_pin_o(rxd_o), .rxd_pin_oe_n(rxd_oe_n), .rx_err_pin(err_p),
		.rx_dv_pin(dv_p), .carrier_and_valid_combined(), .col_strap_i(col_i),
		.irq_req, .irq_pin_i(irq_i), .irq_out_low(irq_lo), .irq_oe_n,
		.tx_error_function(txf), .tx_symbol_msb(), .opmode_strap_bit0(),
		.opmode_strap_bit1(), .opmode_strap_bit2(),
		.irq_pin_function_strap(), .rmii_sel(rmii));
	mac_rx_model u_mac (.rx_clk, .strap, .strap_col(col), .txe, .rmii,
		.rxd_pin_o(rxd_o), .rxd_pin_oe_n(rxd_oe_n), .rx_err_pin(err_p),
		.rx_dv_pin(dv_p), .irq_out_low(irq_lo), .irq_oe_n,
		.rxd_pin_i(rxd_i), .col_strap_i(col_i), .irq_pin_i(irq_i), .cap);
	task automatic results();
		$display("mismatches %0d compares %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : results
	task automatic cmp_apb(input logic [32:0] e, input logic [32:0] s);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD apb read exp %h got %h", e, s);
		end
	endtask : cmp_apb
	task automatic cmp_rx(input logic [4:0] e, input logic [4:0] s);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD rx nibble exp %h got %h", e, s);
		end
	endtask : cmp_rx
	task automatic cmp_pin(input logic e, input logic s);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD tx error pin exp %b got %b", e, s);
		end
	endtask : cmp_pin
	// one apb transfer, held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		q_apb.push_back(e);
		apb(0, a, 32'h0000_0000);
	endtask : rd
	// reset long enough for the rx side to see three edges
	task automatic rst(input logic [3:0] s, input logic c);
		strap <= s;
		col <= c;
		srst <= 1;
		repeat (50) @(posedge clk);
		srst <= 0;
		repeat (60) @(posedge clk);
	endtask : rst
	task automatic frame(input int n, input logic sym);
		logic [3:0] nb;
		logic m;
		for (int i = 0; i < n; i++) begin
			nb = 4'($urandom);
			m = 1'($urandom);
			@(posedge rx_clk);
			dec_nibble <= nb;
			dec_sym_msb <= m;
			dec_err <= (i == 2) && !sym;
			dec_valid <= 1;
			dec_carrier <= 1;
			if (!col) q_rx.push_back({sym ? m : (i == 2), nb});
		end
		@(posedge rx_clk);
		dec_valid <= 0;
		dec_err <= 0;
		dec_carrier <= 0;
		repeat (4) @(posedge rx_clk);
	endtask : frame
	// result watchers and the hang limit
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			results();
		end
		if (pready && !pwrite && q_apb.size() > 0)
			cmp_apb(q_apb.pop_front(), {pslverr, prdata});
	end
	always @(posedge rx_clk)
		if (cap[4] && q_rx.size() > 0)
			cmp_rx(q_rx.pop_front(), {cap[5], cap[3:0]});
	initial begin
		logic [2:0] md;
		void'($urandom(42565));
		md = 3'($urandom);
		rst({1'b1, md}, 0);
		rd(mii_rx_pkg::REG_CTRL, 33'h0_0000_0002);
		rd(mii_rx_pkg::REG_STATUS, {1'b0, 32'h0000_0048 | 32'(md)});
		rd(8'h0c, 33'h1_0000_0000);
		frame(8, 0);
		rd(mii_rx_pkg::REG_ERRCNT, 33'h0_0000_0001);
		apb(1, mii_rx_pkg::REG_ERRCNT, 32'h0000_0000);
		rd(mii_rx_pkg::REG_ERRCNT, 33'h0_0000_0000);
		irq_req <= 1;
		repeat (3) @(posedge clk);
		irq_req <= 0;
		apb(1, mii_rx_pkg::REG_CTRL, 32'h0000_0003);
		repeat (4) @(posedge rx_clk);
		frame(6, 1);
		rd(mii_rx_pkg::REG_STATUS, {1'b0, 32'h0000_00c8 | 32'(md)});
		md = 3'($urandom);
		rst({1'b0, md}, 1);
		rd(mii_rx_pkg::REG_STATUS, {1'b0, 32'h0000_0050 | 32'(md)});
		cmp_pin(1'b1, txf);
		txe <= 0;
		repeat (4) @(posedge clk);
		cmp_pin(1'b0, txf);
		irq_req <= 1;
		repeat (3) @(posedge clk);
		irq_req <= 0;
		frame(4, 0);
		cmp_rx(5'h00, 5'(q_rx.size()));
		repeat (2) @(posedge clk);
		results();
	end
endmodule : tb_top
`default_nettype wire
